// [pkg/mdt_pkg.sv]
package mdt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_DIN     = 8'h04;
  localparam logic [7:0] OFS_DOUT    = 8'h08;
  localparam logic [7:0] OFS_PAT     = 8'h0C;
  localparam logic [7:0] OFS_TOT     = 8'h10;
  localparam logic [7:0] OFS_SCAN    = 8'h14;
  localparam logic [7:0] OFS_DAC0    = 8'h18;
  localparam logic [7:0] OFS_DAC1    = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h24;
  // control field positions
  localparam int CTRL_JOIN  = 0;  // 16-bit joined output writes
  localparam int CTRL_FALL  = 1;  // totalizer counts falling edges
  localparam int CTRL_CHG0  = 2;  // port 0 alarm on change, else match
  localparam int CTRL_CHG1  = 3;  // port 1 alarm on change, else match
  localparam int CTRL_OE0   = 4;  // port 0 drives its pins
  localparam int CTRL_OE1   = 5;  // port 1 drives its pins
  localparam int CTRL_W     = 6;
  // scan selector codes
  localparam logic [1:0] SCAN_P0  = 2'h0;
  localparam logic [1:0] SCAN_P1  = 2'h1;
  localparam logic [1:0] SCAN_TOT = 2'h2;
  // interrupt status bits
  localparam int IRQ_AL0  = 0;
  localparam int IRQ_AL1  = 1;
  localparam int IRQ_ROLL = 2;
  localparam int IRQ_SCAN = 3;
  localparam int IRQ_W    = 4;
  // widths and limits
  localparam int PORT_W = 8;
  localparam int TOT_W  = 26;
  localparam int DAC_W  = 16;
  localparam logic [25:0] TOT_MAX = 26'h3FFFFFF;
  // dac codes are signed millivolts, clamped to the output span
  localparam logic signed [15:0] DAC_MAX_MV = 16'sh2EE0;
  localparam logic signed [15:0] DAC_MIN_MV = -16'sh2EE0;
  // reset values
  localparam logic [5:0]  CTRL_RST = 6'h00;
  localparam logic [15:0] DOUT_RST = 16'hFFFF;
  localparam logic [15:0] PAT_RST  = 16'h0000;
  localparam logic [15:0] DAC_RST  = 16'h0000;
  localparam logic [3:0]  MSK_RST  = 4'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mdt_pkg

// [hw/mdt_top.sv]
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
// What this block does
// R1 - two 8-bit ports, live levels readable anytime
// R2 - port value capturable as a scan step
// R3 - alarm on pattern match or pattern change
// R4 - alarm works regardless of scan selection
// R5 - open input reads one, grounded reads zero
// R6 - ports output separately or as 16-bit word
// R7 - host drives bit low to switch external
// R8 - 26-bit counter, pulses up to 100 kHz
// R9 - count readable directly or by scan
// R10 - rising or falling counting edge selectable
// R11 - count wraps from maximum to zero
// R12 - high gate enables while high
// R13 - low gate enables while low
// R14 - count only when both gates enable
// R15 - unconnected gates float to enabling state
// R16 - two DAC channels with 16-bit codes
// R17 - codes span minus to plus 12 V, 1 mV
// R18 - counter and gate inputs synchronized first
module mdt_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // digital port pins, port 0 in bits 7:0
  input  wire logic [15:0] dio_in,
  output logic [15:0]      dio_out,
  output logic [15:0]      dio_oe,
  // totalizer input and gates
  input  wire logic        tot_in,
  input  wire logic        gate_hi,
  input  wire logic        gate_lo_n,
  // dac setpoints and interrupt
  output logic [15:0]      dac0_code,
  output logic [15:0]      dac1_code,
  output logic             irq
);
  logic [5:0]  ctrl;        // mode bits
  logic [15:0] pat;         // alarm patterns, port 1 high byte
  logic [25:0] tot_cnt;     // totalizer count
  logic [25:0] scan_data;   // last scanned value
  logic        scan_valid;  // a scan step has completed
  logic [3:0]  irq_st;      // sticky events
  logic [3:0]  irq_msk;     // event enables
  logic [15:0] din_q;       // registered pin levels
  logic [15:0] din_prev;    // previous sample for change alarms
  logic        aw_held;     // address latched, waiting for data
  logic        w_held;      // data latched, waiting for address
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  // the write lands once both halves are present and no response waits
  wire wr_fire = (aw_held | aw_take) & (w_held | w_take) & ~s_axi_bvalid;

  // write decode
  wire wr_ctrl = wr_fire & (wa == mdt_pkg::OFS_CTRL);
  wire wr_dout = wr_fire & (wa == mdt_pkg::OFS_DOUT);
  wire wr_pat  = wr_fire & (wa == mdt_pkg::OFS_PAT);
  wire wr_scan = wr_fire & (wa == mdt_pkg::OFS_SCAN);
  wire wr_dac0 = wr_fire & (wa == mdt_pkg::OFS_DAC0);
  wire wr_dac1 = wr_fire & (wa == mdt_pkg::OFS_DAC1);
  wire wr_msk  = wr_fire & (wa == mdt_pkg::OFS_IRQ_MSK);
  wire wr_ok   = wr_ctrl | wr_dout | wr_pat | wr_scan | wr_dac0 | wr_dac1
               | wr_msk | (wa == mdt_pkg::OFS_DIN)
               | (wa == mdt_pkg::OFS_TOT) | (wa == mdt_pkg::OFS_IRQ_ST);

  // address and data channel handshakes; ready only while empty
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_held       <= (aw_held | aw_take) & ~wr_fire;
      w_held        <= (w_held | w_take) & ~wr_fire;
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= ~(aw_held | aw_take) | wr_fire;
      s_axi_wready  <= ~(w_held | w_take) | wr_fire;
    end
  end

  // write response: unmapped offsets answer slverr
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mdt_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? mdt_pkg::RESP_OKAY : mdt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // control, pattern and mask registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl    <= mdt_pkg::CTRL_RST;
      pat     <= mdt_pkg::PAT_RST;
      irq_msk <= mdt_pkg::MSK_RST;
    end else begin
      if (wr_ctrl & ws[0]) ctrl <= wd[5:0];
      if (wr_pat & ws[0]) pat[7:0] <= wd[7:0];
      if (wr_pat & ws[1]) pat[15:8] <= wd[15:8];
      if (wr_msk & ws[0]) irq_msk <= wd[3:0];
    end
  end
  // joined mode updates both bytes from one write, so the pins never
  // show a half-written 16-bit word
  wire join16   = ctrl[mdt_pkg::CTRL_JOIN];
  wire dout_lo  = wr_dout & (join16 ? |ws[1:0] : ws[0]);
  wire dout_hi  = wr_dout & (join16 ? |ws[1:0] : ws[1]);

  // output latch; reset high so attached switches sit released
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dio_out <= mdt_pkg::DOUT_RST;
      dio_oe  <= 16'h0000;
    end else begin
      if (dout_lo) dio_out[7:0] <= wd[7:0];           // [R6] [R7]
      if (dout_hi) dio_out[15:8] <= wd[15:8];         // [R6]
      dio_oe <= {{8{ctrl[mdt_pkg::CTRL_OE1]}},
                 {8{ctrl[mdt_pkg::CTRL_OE0]}}};
    end
  end
  // pins are taken without inversion: the pull-up makes an open
  // contact a one, a closure to ground a zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      din_q    <= 16'hFFFF;
      din_prev <= 16'hFFFF;
    end else begin
      din_q    <= dio_in;                              // [R1] [R5]
      din_prev <= din_q;
    end
  end

  // per-port alarm detect, independent of the scan selector
  logic [1:0] alarm_ev;
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      wire [7:0] cur  = din_q[gp*8 +: 8];
      wire [7:0] prv  = din_prev[gp*8 +: 8];
      wire       hit  = (cur == pat[gp*8 +: 8]);
      wire       chg  = ctrl[mdt_pkg::CTRL_CHG0 + gp];
      logic      match_q;  // pattern seen last cycle, one per port
      // match raises an event on entering the pattern, not every cycle
      assign alarm_ev[gp] = chg ? (cur != prv) : (hit & ~match_q);
      always_ff @(posedge mclk) begin
        if (!rst_n) match_q <= 1'b0;
        else match_q <= hit;                           // [R3] [R4]
      end
    end
  endgenerate
  // two-stage synchronizers; only stage two and later feed logic
  logic [1:0] tot_sync;
  logic [1:0] gh_sync;
  logic [1:0] gl_sync;
  logic       tot_last;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tot_sync <= 2'b00;
      gh_sync  <= 2'b11;
      gl_sync  <= 2'b00;
      tot_last <= 1'b0;
    end else begin
      tot_sync <= {tot_sync[0], tot_in};               // [R18]
      gh_sync  <= {gh_sync[0], gate_hi};               // [R18]
      gl_sync  <= {gl_sync[0], gate_lo_n};             // [R18]
      tot_last <= tot_sync[1];
    end
  end

  wire tot_rise = tot_sync[1] & ~tot_last;
  wire tot_fall = ~tot_sync[1] & tot_last;
  wire tot_edge = ctrl[mdt_pkg::CTRL_FALL] ? tot_fall : tot_rise;  // [R10]
  // floating gates are pulled to their enabling level outside
  wire gate_en  = gh_sync[1] & ~gl_sync[1];  // [R12] [R13] [R14] [R15]
  wire tot_step = tot_edge & gate_en;
  wire tot_roll = tot_step & (tot_cnt == mdt_pkg::TOT_MAX);

  // one count per qualified edge; 50 MHz sampling covers 100 kHz input
  always_ff @(posedge mclk) begin
    if (!rst_n) tot_cnt <= 26'h0000000;
    else if (tot_roll) tot_cnt <= 26'h0000000;         // [R11]
    else if (tot_step) tot_cnt <= tot_cnt + 26'h0000001;  // [R8]
  end
  // a write to the scan register samples the chosen source at once
  wire [1:0]  scan_sel = wd[1:0];
  wire [25:0] scan_p0  = {18'h00000, din_q[7:0]};   // port 0, zero-extended
  wire [25:0] scan_p1  = {18'h00000, din_q[15:8]};  // port 1, zero-extended
  wire [25:0] scan_val = (scan_sel == mdt_pkg::SCAN_P0) ? scan_p0
                       : (scan_sel == mdt_pkg::SCAN_P1) ? scan_p1
                       : tot_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scan_data  <= 26'h0000000;
      scan_valid <= 1'b0;
    end else if (wr_scan & ws[0]) begin
      scan_data  <= scan_val;                          // [R2] [R9]
      scan_valid <= 1'b1;
    end
  end
  // codes are signed millivolts; out-of-span writes saturate
  wire signed [15:0] dac_in = wd[15:0];
  wire [15:0] dac_sat = (dac_in > mdt_pkg::DAC_MAX_MV) ? mdt_pkg::DAC_MAX_MV
                      : (dac_in < mdt_pkg::DAC_MIN_MV) ? mdt_pkg::DAC_MIN_MV
                      : wd[15:0];
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dac0_code <= mdt_pkg::DAC_RST;
      dac1_code <= mdt_pkg::DAC_RST;
    end else begin
      if (wr_dac0 & (&ws[1:0])) dac0_code <= dac_sat;  // [R16] [R17]
      if (wr_dac1 & (&ws[1:0])) dac1_code <= dac_sat;  // [R16] [R17]
    end
  end
  // read address decode
  wire rd_take = s_axi_arvalid & s_axi_arready;
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      mdt_pkg::OFS_CTRL:    rd_mux = {26'h0000000, ctrl};
      mdt_pkg::OFS_DIN:     rd_mux = {16'h0000, din_q};       // [R1]
      mdt_pkg::OFS_DOUT:    rd_mux = {16'h0000, dio_out};
      mdt_pkg::OFS_PAT:     rd_mux = {16'h0000, pat};
      mdt_pkg::OFS_TOT:     rd_mux = {6'h00, tot_cnt};        // [R9]
      mdt_pkg::OFS_SCAN:    rd_mux = {scan_valid, 5'h00, scan_data};
      mdt_pkg::OFS_DAC0:    rd_mux = {16'h0000, dac0_code};
      mdt_pkg::OFS_DAC1:    rd_mux = {16'h0000, dac1_code};
      mdt_pkg::OFS_IRQ_ST:  rd_mux = {28'h0000000, irq_st};
      mdt_pkg::OFS_IRQ_MSK: rd_mux = {28'h0000000, irq_msk};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= mdt_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? mdt_pkg::RESP_OKAY : mdt_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // interrupt status, read to clear
  wire [3:0] ev_set = {wr_scan & ws[0], tot_roll, alarm_ev};
  wire rd_clr = rd_take & (s_axi_araddr == mdt_pkg::OFS_IRQ_ST);
  // a set in the clearing cycle survives the read-clear
  wire [3:0] next_irq_st = (rd_clr ? 4'h0 : irq_st) | ev_set;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_st <= 4'h0;
      irq    <= 1'b0;
    end else begin
      irq_st <= next_irq_st;                           // [R3]
      irq    <= |(next_irq_st & irq_msk);
    end
  end
  // checks on the count, ports, scan and dac path
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_edge_gated;
    tot_edge & gate_en & (tot_cnt != mdt_pkg::TOT_MAX);
  endsequence
  property p_count_step;
    s_edge_gated |=> (tot_cnt == $past(tot_cnt) + 26'h0000001);
  endproperty
  a_count_step: assert property (p_count_step)  // [R8]
    else $error("count did not step on gated edge");
  property p_wrap;
    (tot_step & (tot_cnt == mdt_pkg::TOT_MAX)) |=> (tot_cnt == 26'h0000000);
  endproperty
  a_wrap: assert property (p_wrap)  // [R11]
    else $error("count did not wrap to zero");
  property p_gate_block;
    (~gh_sync[1] | gl_sync[1]) |=> $stable(tot_cnt);
  endproperty
  a_gate_block: assert property (p_gate_block)  // [R14]
    else $error("count moved while gated off");
  property p_edge_sel;
    (ctrl[mdt_pkg::CTRL_FALL] & tot_rise) |-> ~tot_step;
  endproperty
  a_edge_sel: assert property (p_edge_sel)  // [R10]
    else $error("rising edge counted in falling mode");
  property p_sync_lat;
    $rose(tot_in) ##1 tot_in |=> tot_sync[1];
  endproperty
  a_sync_lat: assert property (p_sync_lat)  // [R18]
    else $error("synchronizer latency wrong");
  property p_live_read;
    rd_take & (s_axi_araddr == mdt_pkg::OFS_DIN)
      |=> s_axi_rvalid & (s_axi_rdata[15:0] == $past(din_q));
  endproperty
  a_live_read: assert property (p_live_read)  // [R1]
    else $error("live port read mismatch");
  property p_alarm;
    (|alarm_ev) |=> (|irq_st[1:0]);
  endproperty
  a_alarm: assert property (p_alarm)  // [R3]
    else $error("alarm event not latched");
  property p_join;
    (wr_dout & join16 & ws[0]) |=> (dio_out == $past(wd[15:0]));
  endproperty
  a_join: assert property (p_join)  // [R6]
    else $error("joined write did not set both ports");
  property p_dac_span;
    ($signed(dac0_code) <= mdt_pkg::DAC_MAX_MV)
      && ($signed(dac0_code) >= mdt_pkg::DAC_MIN_MV);
  endproperty
  a_dac_span: assert property (p_dac_span)  // [R17]
    else $error("dac code outside span");
  property p_scan;
    (wr_scan & ws[0] & (scan_sel == mdt_pkg::SCAN_TOT))
      |=> scan_valid & (scan_data == $past(tot_cnt));
  endproperty
  a_scan: assert property (p_scan)  // [R9]
    else $error("scan did not capture count");

endmodule : mdt_top

// [bench/mdt_field.sv]
`timescale 1ns/10ps
// field wiring beside the module: contacts, pulse source, gate terminals
module mdt_field (
  // clock
  input  wire logic        mclk,
  // module pins seen from the field
  input  wire logic [15:0] dio_out,
  input  wire logic [15:0] dio_oe,
  output logic      [15:0] dio_in,
  output logic             tot_in,
  output logic             gate_hi,
  output logic             gate_lo_n,
  output logic      [1:0]  sw_pos,
  // bench control of the wiring
  input  wire logic [15:0] gnd,
  input  wire logic        gh_con,
  input  wire logic        gh_val,
  input  wire logic        gl_con,
  input  wire logic        gl_val,
  input  wire logic        lvl,
  input  wire logic [7:0]  npulse,
  input  wire logic        go,
  output logic             busy
);
  logic [7:0] left = 8'h00; // pulses still to send
  logic [2:0] ph   = 3'h0;  // phase inside one pulse
  // a driven bit wins; else a grounded contact or the pull-up level
  assign dio_in    = (dio_oe & dio_out) | (~dio_oe & ~gnd);
  // an open gate terminal floats to its enabling level
  assign gate_hi   = gh_con ? gh_val : 1'b1;
  assign gate_lo_n = gl_con ? gl_val : 1'b0;
  // a switch position is picked by the bit pulled low
  assign sw_pos    = ~dio_in[1:0];
  assign busy      = (left != 8'h00);
  // pulses three cycles high, three low; a static level otherwise
  assign tot_in    = busy ? (ph < 3'h3) : lvl;
  // pulse train sequencer
  always_ff @(posedge mclk) begin
    if (go) begin
      left <= npulse;
      ph   <= 3'h0;
    end else if (busy) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h5) left <= left - 8'h01;
    end
  end
endmodule : mdt_field

// [bench/testbench.sv]
`timescale 1ns/10ps
// register-level bench: axi4-lite master tasks plus field control
module testbench;
  logic        mclk, rst_n;          // clock and reset
  logic [7:0]  awaddr, araddr;       // axi addresses
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;                // write word
  logic [3:0]  wstrb;                // byte enables
  wire         awready, wready, bvalid, arready, rvalid, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] dio_in, dio_out, dio_oe, dac0, dac1;
  wire         tot_in, gate_hi, gate_lo_n, busy;
  wire  [1:0]  sw_pos;
  logic [15:0] gnd;                  // contacts closed to ground
  logic        gh_con, gh_val, gl_con, gl_val, lvl, go;
  logic [7:0]  npulse;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          n_mismatch, total_checks;

  mdt_top u_dut (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dio_in(dio_in),
    .dio_out(dio_out), .dio_oe(dio_oe), .tot_in(tot_in),
    .gate_hi(gate_hi), .gate_lo_n(gate_lo_n), .dac0_code(dac0),
    .dac1_code(dac1), .irq(irq));
  mdt_field u_field (
    .mclk(mclk), .dio_out(dio_out), .dio_oe(dio_oe), .dio_in(dio_in),
    .tot_in(tot_in), .gate_hi(gate_hi), .gate_lo_n(gate_lo_n),
    .sw_pos(sw_pos), .gnd(gnd), .gh_con(gh_con), .gh_val(gh_val),
    .gl_con(gl_con), .gl_val(gl_val), .lvl(lvl), .npulse(npulse),
    .go(go), .busy(busy));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // verdict, shared by the main sequence and the watchdog
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // one comparison; four-state equality so an x in seen matches only an x in exp
  task automatic chk(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  // axi write; bready rises with the request and drops after bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF,
                    input logic [1:0] er = mdt_pkg::RESP_OKAY);
    int k = 0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 200);
    bready <= 1'b0;
    chk({31'h0, bvalid}, 32'h1, "write answer");
    chk({30'h0, bresp}, {30'h0, er}, "write resp");
  endtask : wr

  // axi read and compare; data taken at the rvalid edge
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er = mdt_pkg::RESP_OKAY);
    int k = 0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 200);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
    chk({31'h0, rvalid}, 32'h1, "read answer");
    chk(rd, exp, "read data");
    chk({30'h0, rsp}, {30'h0, er}, "read resp");
  endtask : rdc

  // send n pulses, then let the two-stage sync and edge detect settle
  task automatic pulse(input logic [7:0] n);
    int k = 0;
    @(posedge mclk) npulse <= n;
    go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    // busy rises only after the edge that takes go
    do begin
      @(posedge mclk);
      k++;
    end while (busy === 1'b1 && k < 5000);
    repeat (6) @(posedge mclk);
  endtask : pulse

  // hang guard: 20000 cycles, many times the expected run length
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, go, lvl} = 8'h00;
    {gh_con, gh_val, gl_con, gl_val} = 4'h0;
    {awaddr, araddr, wdata, wstrb, npulse} = 60'h0;
    gnd = 16'h00A5;
    n_mismatch = 0;
    total_checks = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk({dio_oe, dio_out}, 32'h0000FFFF, "pins after reset");
    chk({dac1, dac0}, 32'h0, "dac after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test reset done");
    rdc(mdt_pkg::OFS_DIN, 32'h0000FF5A);
    wr(mdt_pkg::OFS_SCAN, 32'h0);
    rdc(mdt_pkg::OFS_SCAN, 32'h8000005A);
    rdc(mdt_pkg::OFS_IRQ_ST, 32'h8);
    // scan-done interrupt raised, cleared by read, then masked
    wr(mdt_pkg::OFS_IRQ_MSK, 32'h8, 4'h1);
    wr(mdt_pkg::OFS_SCAN, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "scan irq");
    rdc(mdt_pkg::OFS_SCAN, 32'h800000FF);
    rdc(mdt_pkg::OFS_IRQ_ST, 32'h8);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    wr(mdt_pkg::OFS_IRQ_MSK, 32'h0, 4'h1);
    wr(mdt_pkg::OFS_SCAN, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rdc(mdt_pkg::OFS_IRQ_ST, 32'h8);
    $display("test scan done");
    // match alarm on port 0 while the scan points at port 1
    wr(mdt_pkg::OFS_PAT, 32'h0F, 4'h1);
    wr(mdt_pkg::OFS_IRQ_MSK, 32'h3, 4'h1);
    @(posedge mclk) gnd <= 16'h00F0;
    repeat (6) @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "match irq");
    rdc(mdt_pkg::OFS_IRQ_ST, 32'h1);
    // change alarm on port 1, then on port 0
    wr(mdt_pkg::OFS_CTRL, 32'h0C, 4'h1);
    @(posedge mclk) gnd <= 16'h01F0;
    repeat (6) @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "change irq");
    rdc(mdt_pkg::OFS_IRQ_ST, 32'h2);
    @(posedge mclk) gnd <= 16'h01F1;
    repeat (6) @(posedge mclk);
    rdc(mdt_pkg::OFS_IRQ_ST, 32'h1);
    $display("test alarm done");
    // outputs per port, then joined as one word
    wr(mdt_pkg::OFS_CTRL, 32'h30, 4'h1);
    repeat (2) @(posedge mclk);
    chk({16'h0, dio_oe}, 32'hFFFF, "drive enable");
    wr(mdt_pkg::OFS_DOUT, 32'h1234, 4'h1);
    chk({16'h0, dio_out}, 32'hFF34, "port 0 only");
    wr(mdt_pkg::OFS_DOUT, 32'h5600, 4'h2);
    chk({16'h0, dio_out}, 32'h5634, "port 1 only");
    wr(mdt_pkg::OFS_CTRL, 32'h31, 4'h1);
    wr(mdt_pkg::OFS_DOUT, 32'hABCD, 4'h1);
    chk({16'h0, dio_out}, 32'hABCD, "joined word");
    rdc(mdt_pkg::OFS_DIN, 32'h0000ABCD);
    wr(mdt_pkg::OFS_DOUT, 32'hFFFE, 4'h3);
    chk({30'h0, sw_pos}, 32'h1, "switch position");
    wr(mdt_pkg::OFS_CTRL, 32'h0, 4'h1);
    $display("test output done");
    // dac codes: in range, clamped both ways, one step below zero
    wr(mdt_pkg::OFS_DAC0, 32'h1234, 4'h3);
    chk({16'h0, dac0}, 32'h1234, "dac0 code");
    wr(mdt_pkg::OFS_DAC1, 32'h8000, 4'h3);
    chk({16'h0, dac1}, 32'hD120, "dac1 low clamp");
    wr(mdt_pkg::OFS_DAC0, 32'h3000, 4'h3);
    chk({16'h0, dac0}, 32'h2EE0, "dac0 high clamp");
    wr(mdt_pkg::OFS_DAC1, 32'hFFFF, 4'h3);
    chk({16'h0, dac1}, 32'hFFFF, "dac1 one step");
    wr(8'h40, 32'h1, 4'hF, mdt_pkg::RESP_SLVERR);
    rdc(8'h40, 32'h0, mdt_pkg::RESP_SLVERR);
    $display("test dac done");
    // totalizer with open gates, then each gate blocking in turn
    pulse(8'd5);
    rdc(mdt_pkg::OFS_TOT, 32'd5);
    @(posedge mclk) gh_con <= 1'b1;
    pulse(8'd3);
    rdc(mdt_pkg::OFS_TOT, 32'd5);
    @(posedge mclk) gh_val <= 1'b1;
    pulse(8'd2);
    rdc(mdt_pkg::OFS_TOT, 32'd7);
    @(posedge mclk) gl_con <= 1'b1;
    gl_val <= 1'b1;
    pulse(8'd3);
    rdc(mdt_pkg::OFS_TOT, 32'd7);
    @(posedge mclk) gl_val <= 1'b0;
    pulse(8'd1);
    rdc(mdt_pkg::OFS_TOT, 32'd8);
    // single levels tell the counting edge apart
    @(posedge mclk) lvl <= 1'b1;
    repeat (6) @(posedge mclk);
    rdc(mdt_pkg::OFS_TOT, 32'd9);
    wr(mdt_pkg::OFS_CTRL, 32'h2, 4'h1);
    @(posedge mclk) lvl <= 1'b0;
    repeat (6) @(posedge mclk);
    rdc(mdt_pkg::OFS_TOT, 32'd10);
    wr(mdt_pkg::OFS_SCAN, 32'h2);
    rdc(mdt_pkg::OFS_SCAN, 32'h8000000A);
    wr(mdt_pkg::OFS_SCAN, 32'h3);
    rdc(mdt_pkg::OFS_SCAN, 32'h8000000A);
    $display("test totalizer done");
    tally_and_finish();
  end
endmodule : testbench
